// File: rtl/option_config_defs.svh
/*
 * Offsets, field positions and reset values of the option configuration block.
 * Assumes inclusion by bare name from design files; definitions only.
 */
`ifndef OPTION_CONFIG_DEFS_SVH
`define OPTION_CONFIG_DEFS_SVH

// ==========================================================
// Register offsets (byte addresses)
`define OFS_CTRL        12'h000
`define OFS_BYTE0       12'h004
`define OFS_BYTE1       12'h008
`define OFS_STATUS      12'h00C
`define OFS_ACTIVE0     12'h010
`define OFS_ACTIVE1     12'h014

// ==========================================================
// Field positions
`define BIT_WDG_HALT    7
`define BIT_WDG_SW      6
`define BIT_RSVD5       5
`define BIT_LVD_N       4
`define BIT_PLL_OFF     3
`define BIT_RANGE_HI    3
`define BIT_RANGE_LO    2
`define CTRL_PROG_BIT   0
`define CTRL_KEY_HI     15
`define CTRL_KEY_LO     8

// ==========================================================
// Values
`define BLANK_BYTE      8'hFF
`define PROG_KEY        8'hA5
`define RANGE_2_4MHZ    2'h2

`endif

// File: rtl/option_config_pkg.sv
/*
 * Types of the option configuration block.
 * Assumes the defs header supplies all numeric constants.
 */
package option_config_pkg;
    typedef logic [7:0]  opt_byte_t;
    typedef logic [11:0] apb_addr_t;
    typedef logic [31:0] apb_data_t;
    typedef enum logic [1:0] {
        st_idle   = 2'b00,
        st_access = 2'b01
    } apb_state_t;
endpackage

// File: rtl/option_byte_configuration.sv
/*
 * Option byte store and static configuration latch, with an APB slave.
 * Assumes an APB master on pclk; mask_coded and the mask_byte inputs are strapped.
 */
// Design decisions made here: the register addresses and the APB slave port.
`timescale 1ns/1ps
`include "option_config_defs.svh"
// ==========================================================
// Notes on behaviour
// RQ1: Byte 0 bit 7 set means entering halt with the watchdog active causes a reset.
// RQ2: Byte 0 bit 6 clear enables the watchdog by hardware, set leaves it to software.
// RQ3: The programmer must keep byte 0 bit 5 at its blank value because it is reserved.
// RQ4: Byte 0 bit 4 low turns the voltage detector on and high turns it off.
// RQ5: Byte 0 bit 3 low enables the clock doubler and high disables it.
// RQ6: The programmer may enable the doubler only with the oscillator range at 2 to 4 MHz.
// RQ7: Unprogrammed option bytes read as all ones.
// RQ8: Option bytes sit outside the normal map and are reachable only in programming mode.
// RQ9: Blank parts select the reserved internal clock so in-circuit programming works.
// RQ10: Mask-coded parts take all options from fixed hardware and allow no programming.
// RQ11: Option bits are latched into static configuration at reset and held until the next.
module option_byte_configuration (
    input  wire logic                          pclk,
    input  wire logic                          presetn,
    input  wire logic                          psel,
    input  wire logic                          penable,
    input  wire logic                          pwrite,
    input  wire option_config_pkg::apb_addr_t  paddr,
    input  wire option_config_pkg::apb_data_t  pwdata,
    input  wire logic [3:0]                    pstrb,
    output logic                               pready,
    output option_config_pkg::apb_data_t       prdata,
    output logic                               pslverr,
    input  wire logic                          mask_coded,
    input  wire option_config_pkg::opt_byte_t  mask_byte0,
    input  wire option_config_pkg::opt_byte_t  mask_byte1,
    output logic                               watchdog_reset_on_halt,
    output logic                               watchdog_software_select,
    output logic                               low_voltage_detect_enable_n,
    output logic                               pll_double_enable,
    output logic [1:0]                         oscillator_range_field,
    output logic                               internal_clock_select,
    output logic                               in_circuit_programming
);
    import option_config_pkg::*;

    // ==========================================================
    // State
    opt_byte_t  nv0_q, nv1_q;          // Non-volatile store model
    opt_byte_t  act0_q, act1_q;        // Static configuration
    logic       latched_q;
    logic       prog_q;
    apb_data_t  prdata_q;
    logic       pslverr_q;

    function automatic logic is_opt(input apb_addr_t a);
        is_opt = (a == `OFS_BYTE0) || (a == `OFS_BYTE1);
    endfunction

    // ==========================================================
    // Decode
    wire        setup     = psel && !penable;
    wire        opt_hit   = is_opt(paddr);
    wire        known     = opt_hit || (paddr == `OFS_CTRL) || (paddr == `OFS_STATUS)
                            || (paddr == `OFS_ACTIVE0) || (paddr == `OFS_ACTIVE1);
    // Option bytes are hidden unless in programming mode on a programmable part
    wire        opt_open  = prog_q && !mask_coded;                          // RQ8 RQ10
    wire        bad       = !known || (opt_hit && !opt_open) || (paddr[1:0] != 2'h0); // RQ8
    // Writes land only at the edge where the access phase completes, as the master expects
    wire        access    = psel && penable;
    wire        do_write  = access && pwrite && !bad;
    wire        key_ok    = pwdata[`CTRL_KEY_HI:`CTRL_KEY_LO] == `PROG_KEY;
    wire        ctrl_wr   = do_write && (paddr == `OFS_CTRL) && pstrb[0] && pstrb[1];
    wire        b0_wr     = do_write && (paddr == `OFS_BYTE0) && pstrb[0];
    wire        b1_wr     = do_write && (paddr == `OFS_BYTE1) && pstrb[0];
    // Reserved bit 5 is not writable, so the blank value always holds
    wire opt_byte_t b0_new = {pwdata[7:6], nv0_q[`BIT_RSVD5], pwdata[4:0]}; // RQ3

    // Fixed hardware replaces the store on mask-coded parts
    wire opt_byte_t src0   = mask_coded ? mask_byte0 : nv0_q;               // RQ10
    wire opt_byte_t src1   = mask_coded ? mask_byte1 : nv1_q;               // RQ10

    wire apb_data_t rd_mux =
        (paddr == `OFS_CTRL)    ? {31'h0, prog_q} :
        (paddr == `OFS_BYTE0)   ? {24'h0, nv0_q} :
        (paddr == `OFS_BYTE1)   ? {24'h0, nv1_q} :
        (paddr == `OFS_STATUS)  ? {29'h0, mask_coded, latched_q, prog_q} :
        (paddr == `OFS_ACTIVE0) ? {24'h0, act0_q} :
        (paddr == `OFS_ACTIVE1) ? {24'h0, act1_q} : 32'h0;

    // ==========================================================
    // Store: shipped blank; writes only in programming mode
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            nv0_q <= `BLANK_BYTE;                                           // RQ7
            nv1_q <= `BLANK_BYTE;                                           // RQ7
        end else begin
            if (b0_wr) nv0_q <= b0_new;                                     // RQ8
            if (b1_wr) nv1_q <= pwdata[7:0];                                // RQ8
        end
    end
    // Limitation: the store model is reset by presetn; a real part keeps it across resets.

    // ==========================================================
    // Programming mode entered and left by keyed control writes
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prog_q <= 1'b0;
        end else if (ctrl_wr && key_ok) begin
            prog_q <= pwdata[`CTRL_PROG_BIT] && !mask_coded;                // RQ10
        end
    end

    // ==========================================================
    // Static configuration caught once, at the first edge after reset release
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            act0_q    <= `BLANK_BYTE;
            act1_q    <= `BLANK_BYTE;
            latched_q <= 1'b0;
        end else if (!latched_q) begin
            act0_q    <= src0;                                              // RQ11
            act1_q    <= src1;                                              // RQ11
            latched_q <= 1'b1;
        end
    end

    // ==========================================================
    // APB answer: registered, no wait state
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_q  <= 32'h0;
            pslverr_q <= 1'b0;
        end else if (setup) begin
            prdata_q  <= (pwrite || bad) ? 32'h0 : rd_mux;
            pslverr_q <= bad;
        end
    end

    assign pready  = psel && penable;
    assign prdata  = prdata_q;
    assign pslverr = pslverr_q && pready;

    // ==========================================================
    // Configuration outputs, from flip-flops, except internal_clock_select, which also gates with mask_coded
    assign watchdog_reset_on_halt      = act0_q[`BIT_WDG_HALT];             // RQ1
    assign watchdog_software_select    = act0_q[`BIT_WDG_SW];               // RQ2
    assign low_voltage_detect_enable_n = act0_q[`BIT_LVD_N];                // RQ4
    assign pll_double_enable           = !act0_q[`BIT_PLL_OFF];             // RQ5
    // The doubler is only trusted with the 2 to 4 MHz range; the programmer owns that pairing
    assign oscillator_range_field      = act1_q[`BIT_RANGE_HI:`BIT_RANGE_LO]; // RQ6
    // A blank part (both bytes all ones) runs from the reserved internal clock
    assign internal_clock_select       = !mask_coded && (act0_q == `BLANK_BYTE)
                                         && (act1_q == `BLANK_BYTE);        // RQ9
    assign in_circuit_programming      = prog_q;
endmodule

// File: verif/option_cfg_asserts.sv
/* Port checker for option_byte_configuration.
   Assumes it is bound to the top module and the defs header is on the path. */
`timescale 1ns/1ps
`include "option_config_defs.svh"
module option_cfg_asserts (
    input wire logic                         pclk,
    input wire logic                         presetn,
    input wire logic                         psel,
    input wire logic                         penable,
    input wire option_config_pkg::apb_addr_t paddr,
    input wire logic                         pready,
    input wire option_config_pkg::apb_data_t prdata,
    input wire logic                         pslverr,
    input wire logic                         mask_coded,
    input wire option_config_pkg::opt_byte_t mask_byte0,
    input wire logic                         watchdog_reset_on_halt,
    input wire logic                         watchdog_software_select,
    input wire logic                         low_voltage_detect_enable_n,
    input wire logic                         pll_double_enable,
    input wire logic                         internal_clock_select,
    input wire logic                         in_circuit_programming
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    // ==========
    // First edge after release loads the straps, so strap checks start one edge later and AST_HOLD two edges later
    AST_READY: assert property (psel && !penable |=> pready) else $error("no ready");
    AST_REFUSE: assert property (psel && !penable && !in_circuit_programming &&
        (paddr == `OFS_BYTE0 || paddr == `OFS_BYTE1) |=> pslverr && prdata == '0) else $error("not refused");
    AST_HOLD: assert property ($past(presetn, 2) && $past(presetn) |-> $stable({watchdog_reset_on_halt,
        watchdog_software_select, low_voltage_detect_enable_n, pll_double_enable})) else $error("cfg moved");
    AST_HALT: assert property (mask_coded && $past(presetn) |-> watchdog_reset_on_halt == mask_byte0[7])
        else $error("halt bit");
    AST_SW: assert property (mask_coded && $past(presetn) |-> watchdog_software_select == mask_byte0[6])
        else $error("sw bit");
    AST_LVD: assert property (mask_coded && $past(presetn) |-> low_voltage_detect_enable_n == mask_byte0[4])
        else $error("lvd bit");
    AST_PLL: assert property (mask_coded && $past(presetn) |-> pll_double_enable == !mask_byte0[3])
        else $error("pll bit");
    AST_NOPROG: assert property (mask_coded |-> !in_circuit_programming) else $error("prog in mask");
    AST_BLANK: assert property (!mask_coded && $past(presetn) |-> internal_clock_select) else $error("clk");
    COV_PROG: cover property (in_circuit_programming);
    COV_REFUSED: cover property (pready && pslverr);
    COV_MASK: cover property (mask_coded && pll_double_enable);
endmodule
bind option_byte_configuration option_cfg_asserts option_cfg_asserts_inst (.*);

// File: verif/prog_tool.sv
/* Programming tool model: APB master that burns option bytes.
   Assumes the bench calls its tasks and shares pclk. */
`timescale 1ns/1ps
`include "option_config_defs.svh"
module prog_tool (
    input  wire logic                         pclk,
    input  wire logic                         pready,
    input  wire option_config_pkg::apb_data_t prdata,
    input  wire logic                         pslverr,
    output logic                              psel,
    output logic                              penable,
    output logic                              pwrite,
    output option_config_pkg::apb_addr_t      paddr,
    output option_config_pkg::apb_data_t      pwdata,
    output logic [3:0]                        pstrb
);
    import option_config_pkg::*;
    initial begin
        {psel, penable, pwrite, paddr, pwdata} = '0;
        pstrb = 4'hF;
    end
    task automatic xfer(input logic w, input apb_addr_t a, input apb_data_t d, output logic [32:0] r);
        @(posedge pclk);
        {psel, pwrite, paddr, pwdata} <= {1'b1, w, a, d};
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        r = {pslverr, prdata};
        {psel, penable} <= 2'b00;
        // Released lines flip so a stale value is never mistaken for a live one
        {paddr, pwdata} <= {~a, ~d};
    endtask
    task automatic burn(input opt_byte_t b0, input opt_byte_t b1, output logic [32:0] r);
        b0[5] = 1'b1;
        if (!b0[3]) b1[3:2] = `RANGE_2_4MHZ;
        xfer(1'b1, `OFS_BYTE0, {24'h0, b0}, r);
        xfer(1'b1, `OFS_BYTE1, {24'h0, b1}, r);
    endtask
endmodule

// File: verif/test_option_byte_configuration.sv
/* Self-checking bench for option_byte_configuration.
   Assumes the checker binds itself and prog_tool drives the bus. */
`timescale 1ns/1ps
`include "option_config_defs.svh"
module test_option_byte_configuration;
    import option_config_pkg::*;
    logic pclk = 1'b0, presetn = 1'b0, mask_coded = 1'b0;
    opt_byte_t mask_byte0 = 8'hFF, mask_byte1 = 8'hFF;
    logic psel, penable, pwrite, pready, pslverr, watchdog_reset_on_halt, watchdog_software_select;
    logic low_voltage_detect_enable_n, pll_double_enable, internal_clock_select, in_circuit_programming;
    logic [1:0] oscillator_range_field;
    logic [3:0] pstrb;
    apb_addr_t paddr;
    apb_data_t pwdata, prdata;
    logic [32:0] r;
    int mismatches = 0, n_tests = 0;
    wire [7:0] cfg = {watchdog_reset_on_halt, watchdog_software_select, low_voltage_detect_enable_n,
        pll_double_enable, oscillator_range_field, internal_clock_select, in_circuit_programming};
    always #5 pclk = ~pclk;
    option_byte_configuration option_byte_configuration_inst (.*);
    prog_tool prog_tool_inst (.*);
    // ==========
    task automatic chk(input logic [32:0] got, input logic [32:0] exp);
        n_tests++;
        if (got !== exp) begin
            mismatches++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic do_reset(input logic m, input opt_byte_t b0, input opt_byte_t b1);
        @(posedge pclk);
        {presetn, mask_coded, mask_byte0, mask_byte1} <= {1'b0, m, b0, b1};
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        repeat (2) @(posedge pclk);
    endtask
    task automatic give_verdict;
        $display("mismatches=%0d n_tests=%0d", mismatches, n_tests);
        if (mismatches == 0 && n_tests > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    // ==========
    initial begin
        do_reset(1'b0, 8'hFF, 8'hFF);
        chk({25'h0, cfg}, 33'hEE);
        prog_tool_inst.xfer(1'b0, `OFS_BYTE0, 32'h0, r);
        chk(r, {1'b1, 32'h0});
        prog_tool_inst.xfer(1'b0, 12'h018, 32'h0, r);
        chk(r, {1'b1, 32'h0});
        prog_tool_inst.xfer(1'b1, `OFS_CTRL, 32'h0000A501, r);
        prog_tool_inst.burn(8'h07, 8'hF3, r);
        prog_tool_inst.xfer(1'b0, `OFS_BYTE0, 32'h0, r);
        chk(r, 33'h27);
        prog_tool_inst.xfer(1'b0, `OFS_BYTE1, 32'h0, r);
        chk(r, 33'hFB);
        chk({25'h0, cfg}, 33'hEF);
        do_reset(1'b1, 8'h27, 8'hFB);
        chk({25'h0, cfg}, 33'h18);
        prog_tool_inst.xfer(1'b1, `OFS_CTRL, 32'h0000A501, r);
        prog_tool_inst.xfer(1'b0, `OFS_BYTE0, 32'h0, r);
        chk(r, {1'b1, 32'h0});
        give_verdict();
    end
    initial begin
        #50000;
        mismatches++;
        give_verdict();
    end
endmodule
